/* hw/cms_exec.sv */
// Move and shift instruction execution unit with APB register view
// Functional notes
// - Right shift: zero in, bit0 to carry
// - Destination zero writes W, one file
// - Copy file sets zero flag, one cycle unless copying from an indirect port
// - Indirect load through selected pointer into W
// - Mode picks pre/post increment or decrement
// - Relative offset -32..31, pointer unchanged
// - Indirect port redirects copy file to pointed location
// - Pointers are 16-bit and wrap
// - Bank literal loads, flags untouched
// - Page latch literal loads, flags untouched
// - Literal loads W, flags untouched
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_exec
	import cms_pkg::*;
#(
	parameter int PTR_W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire cms_instr_t   instr_i,
	output logic              instr_ready,
	output cms_mem_req_t      mem_req,
	input  wire logic         mem_rvalid,
	input  wire logic [7:0]   mem_rdata,
	output cms_file_wr_t      file_wr,
	output logic              done,
	output logic [7:0]        wreg,
	output logic              c_flag,
	output logic              z_flag,
	output logic [5:0]        bank_select_register,
	output logic [6:0]        program_counter_high_latch,
	output logic [PTR_W-1:0]  pointer_register [2]
);

	// True for the two file addresses that have no storage
	function automatic logic is_ind(input logic [6:0] a);
		is_ind = (a == `CMS_IND0_ADDR) || (a == `CMS_IND1_ADDR);
	endfunction : is_ind

	cms_state_t  state;
	logic        ctrl_en;
	cms_op_t     pend_op;
	logic        pend_dest;
	logic [15:0] pend_ea;

	// Unpacked instruction fields
	cms_op_t     in_op;
	logic [7:0]  in_fdata;
	logic        in_dest;
	logic        in_sel;
	assign in_op    = instr_i.op;
	assign in_fdata = instr_i.f_data;
	assign in_dest  = instr_i.dest;
	assign in_sel   = instr_i.ptr_sel;

	logic             fire;
	logic             need_mem;
	logic             mem_done;
	logic             fin;
	cms_op_t          cur_op;
	logic             cur_dest;
	logic [7:0]       src;
	logic [7:0]       next_res;
	logic             next_c;
	logic             upd_c;
	logic             upd_z;
	logic             wr_w;
	logic             wr_file;
	logic             wr_mem;
	logic [PTR_W-1:0] ptr_cur;
	logic [PTR_W-1:0] next_ptr;
	logic [PTR_W-1:0] ea;
	logic             ptr_upd;
	logic             sel_ptr;

	assign instr_ready = (state == CMS_IDLE) && ctrl_en;
	assign fire        = instr_ready && instr_i.valid;
	// Copy from an indirect port needs the data memory too
	assign need_mem    = (in_op == indirect_load_op) || ((in_op == copy_file_op) && is_ind(instr_i.f_addr));
	assign mem_done    = (state == CMS_WAIT_RD) && mem_rvalid;
	assign fin         = (fire && !need_mem) || mem_done;
	assign cur_op      = (state == CMS_IDLE) ? in_op : pend_op;
	assign cur_dest    = (state == CMS_IDLE) ? in_dest : pend_dest;
	assign src         = (state == CMS_IDLE) ? in_fdata : mem_rdata;

	// Copy through an indirect port uses the port's own pointer
	assign sel_ptr = (in_op == copy_file_op) ? (instr_i.f_addr == `CMS_IND1_ADDR) : in_sel;
	assign ptr_cur = pointer_register[sel_ptr];

	// Effective address and pointer write-back
	always_comb begin
		ea       = ptr_cur;
		next_ptr = ptr_cur;
		ptr_upd  = 1'b0;
		if (in_op == indirect_load_op) begin
			if (instr_i.rel) begin
				ea = ptr_cur + {{(PTR_W-6){instr_i.offset[5]}}, instr_i.offset};
			end else begin
				ptr_upd = 1'b1;
				case (instr_i.pointer_update_mode)
					`CMS_MODE_PREINC: begin
						next_ptr = ptr_cur + 1'b1;
						ea       = next_ptr;
					end
					`CMS_MODE_PREDEC: begin
						next_ptr = ptr_cur - 1'b1;
						ea       = next_ptr;
					end
					`CMS_MODE_POSTINC: next_ptr = ptr_cur + 1'b1;
					default: next_ptr = ptr_cur - 1'b1;
				endcase
			end
		end
	end

	// Result, flags and destination decode
	always_comb begin
		next_res = src;
		next_c   = c_flag;
		upd_c    = 1'b0;
		upd_z    = 1'b0;
		wr_w     = 1'b0;
		wr_file  = 1'b0;
		wr_mem   = 1'b0;
		case (cur_op)
			logical_shift_right_op: begin
				next_res = {1'b0, src[7:1]};
				next_c   = src[0];
				upd_c    = 1'b1;
				upd_z    = 1'b1;
				wr_w     = !cur_dest;
				wr_file  = cur_dest;
			end
			copy_file_op: begin
				upd_z   = 1'b1;
				wr_w    = !cur_dest;
				wr_file = cur_dest && (state == CMS_IDLE);
				wr_mem  = cur_dest && (state == CMS_WAIT_RD);
			end
			indirect_load_op: begin
				upd_z = 1'b1;
				wr_w  = 1'b1;
			end
			load_literal_op: begin
				next_res = instr_i.literal;
				wr_w     = 1'b1;
			end
			default: begin
				next_res = src;
			end
		endcase
	end

	// Sequencer: one cycle unless a memory read is outstanding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= CMS_IDLE;
			pend_op   <= CMS_NOP;
			pend_dest <= 1'b0;
			pend_ea   <= 16'h0000;
		end else if (fire && need_mem) begin
			state     <= CMS_WAIT_RD;
			pend_op   <= in_op;
			pend_dest <= in_dest;
			pend_ea   <= ea;
		end else if (mem_done) begin
			state <= CMS_IDLE;
		end
	end

	// Memory request: read on issue, write-back for redirected copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= '0;
		end else if (fire && need_mem) begin
			mem_req <= '{valid: 1'b1, we: 1'b0, addr: ea, wdata: 8'h00};
		end else if (fin && wr_mem) begin
			mem_req <= '{valid: 1'b1, we: 1'b1, addr: pend_ea, wdata: next_res};
		end else begin
			mem_req <= '0;
		end
	end

	// File register write-back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			file_wr <= '0;
			done    <= 1'b0;
		end else begin
			file_wr <= '{valid: fin && wr_file, addr: instr_i.f_addr, data: next_res};
			done    <= fin;
		end
	end

	// APB decode
	logic apb_wr;
	logic hit;
	assign apb_wr  = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign hit     = (paddr == `CMS_OFF_CTRL) || (paddr == `CMS_OFF_STATUS) || (paddr == `CMS_OFF_WREG)
		|| (paddr == `CMS_OFF_BANK) || (paddr == `CMS_OFF_PCHIGH) || (paddr == `CMS_OFF_PTR0)
		|| (paddr == `CMS_OFF_PTR1);
	assign pslverr = psel && penable && !hit;

	always_comb begin
		prdata = 32'h0000_0000;
		if (paddr == `CMS_OFF_CTRL) begin
			prdata[`CMS_CTRL_EN_BIT] = ctrl_en;
		end else if (paddr == `CMS_OFF_STATUS) begin
			prdata[`CMS_STAT_C_BIT]   = c_flag;
			prdata[`CMS_STAT_Z_BIT]   = z_flag;
			prdata[`CMS_STAT_BSY_BIT] = (state != CMS_IDLE);
		end else if (paddr == `CMS_OFF_WREG) begin
			prdata[7:0] = wreg;
		end else if (paddr == `CMS_OFF_BANK) begin
			prdata[5:0] = bank_select_register;
		end else if (paddr == `CMS_OFF_PCHIGH) begin
			prdata[6:0] = program_counter_high_latch;
		end else if (paddr == `CMS_OFF_PTR0) begin
			prdata[PTR_W-1:0] = pointer_register[0];
		end else if (paddr == `CMS_OFF_PTR1) begin
			prdata[PTR_W-1:0] = pointer_register[1];
		end
	end

	// Control register gates instruction issue
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en <= `CMS_RST_CTRL;
		end else if (apb_wr && paddr == `CMS_OFF_CTRL) begin
			ctrl_en <= pwdata[`CMS_CTRL_EN_BIT];
		end
	end

	// Working register; execution wins over a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wreg <= `CMS_RST_WREG;
		end else if (fin && wr_w) begin
			wreg <= next_res;
		end else if (apb_wr && paddr == `CMS_OFF_WREG) begin
			wreg <= pwdata[7:0];
		end
	end

	// Status flags; literal loads never touch them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_flag <= 1'b0;
			z_flag <= 1'b0;
		end else if (fin && (upd_c || upd_z)) begin
			if (upd_c) begin
				c_flag <= next_c;
			end
			z_flag <= (next_res == 8'h00);
		end else if (apb_wr && paddr == `CMS_OFF_STATUS) begin
			c_flag <= pwdata[`CMS_STAT_C_BIT];
			z_flag <= pwdata[`CMS_STAT_Z_BIT];
		end
	end

	// Bank select and page latch literals
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_select_register       <= `CMS_RST_BANK;
			program_counter_high_latch <= `CMS_RST_PCHIGH;
		end else if (fire && in_op == load_bank_select_op) begin
			bank_select_register <= instr_i.literal[5:0];
		end else if (fire && in_op == load_page_latch_op) begin
			program_counter_high_latch <= instr_i.literal[6:0];
		end else if (apb_wr && paddr == `CMS_OFF_BANK) begin
			bank_select_register <= pwdata[5:0];
		end else if (apb_wr && paddr == `CMS_OFF_PCHIGH) begin
			program_counter_high_latch <= pwdata[6:0];
		end
	end

	// Pointer registers; wrap comes free from the fixed width
	for (genvar i = 0; i < 2; i++) begin : g_ptr
		logic [11:0] ptr_off;
		assign ptr_off = (i == 0) ? `CMS_OFF_PTR0 : `CMS_OFF_PTR1;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pointer_register[i] <= `CMS_RST_PTR;
			end else if (fire && ptr_upd && sel_ptr == 1'(i)) begin
				pointer_register[i] <= next_ptr;
			end else if (apb_wr && paddr == ptr_off) begin
				pointer_register[i] <= pwdata[PTR_W-1:0];
			end
		end
	end

	// Checks on the execution behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	shift_carry_a: assert property (fire && in_op == logical_shift_right_op
		|=> c_flag == $past(in_fdata[0]) && z_flag == ($past(in_fdata[7:1]) == 7'h00))
		else $error("shift carry wrong");
	dest_sel_a: assert property (fire && in_op == logical_shift_right_op && in_dest
		|=> file_wr.valid && file_wr.data == {1'b0, $past(in_fdata[7:1])} && wreg == $past(wreg)
		&& file_wr.addr == $past(instr_i.f_addr))
		else $error("shift destination wrong");
	copy_one_a: assert property (fire && in_op == copy_file_op && !is_ind(instr_i.f_addr)
		|=> done && z_flag == ($past(in_fdata) == 8'h00))
		else $error("copy file not one cycle");
	iload_w_a: assert property (mem_done && pend_op == indirect_load_op
		|=> wreg == $past(mem_rdata) && done)
		else $error("indirect load wrong");
	ptr_mode_a: assert property (fire && in_op == indirect_load_op && !instr_i.rel
		&& instr_i.pointer_update_mode == `CMS_MODE_PREINC && !in_sel
		|=> pointer_register[0] == $past(pointer_register[0]) + 16'h0001 && mem_req.addr == pointer_register[0])
		else $error("preincrement wrong");
	rel_keep_a: assert property (fire && in_op == indirect_load_op && instr_i.rel
		|=> pointer_register[0] == $past(pointer_register[0]) && pointer_register[1] == $past(pointer_register[1]))
		else $error("relative form moved pointer");
	ind_redirect_a: assert property (fire && in_op == copy_file_op && is_ind(instr_i.f_addr)
		|=> mem_req.valid && !mem_req.we && !file_wr.valid)
		else $error("indirect port not redirected");
	redirect_wr_a: assert property (mem_done && pend_op == copy_file_op && pend_dest
		|=> mem_req.valid && mem_req.we && mem_req.addr == $past(pend_ea) && mem_req.wdata == $past(mem_rdata))
		else $error("indirect write-back wrong");
	ptr_wrap_a: assert property (fire && in_op == indirect_load_op && !instr_i.rel && !in_sel
		&& instr_i.pointer_update_mode == `CMS_MODE_POSTDEC && pointer_register[0] == 16'h0000
		|=> pointer_register[0] == 16'hffff)
		else $error("pointer did not wrap");
	bank_a: assert property (fire && in_op == load_bank_select_op
		|=> bank_select_register == $past(instr_i.literal[5:0]) && $stable(c_flag) && $stable(z_flag))
		else $error("bank select load wrong");
	page_a: assert property (fire && in_op == load_page_latch_op
		|=> program_counter_high_latch == $past(instr_i.literal[6:0]) && $stable(z_flag))
		else $error("page latch load wrong");
	literal_a: assert property (fire && in_op == load_literal_op
		|=> wreg == $past(instr_i.literal) && $stable(c_flag) && $stable(z_flag) && done)
		else $error("literal load wrong");
	zero_flag_a: assert property (fin && upd_z |=> z_flag == ($past(next_res) == 8'h00))
		else $error("zero flag wrong");

	shift_c: cover property (fire && in_op == logical_shift_right_op && in_fdata[0]);
	iload_c: cover property (fire && in_op == indirect_load_op ##[1:8] mem_done);
	redirect_c: cover property (mem_done && pend_op == copy_file_op && pend_dest);
	wrap_c: cover property (fire && in_op == indirect_load_op && ptr_cur == 16'hffff && ptr_upd);

endmodule : cms_exec

/* hw/cms_params.svh */
// Constants for the move and shift execution block
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// APB register byte offsets
`define CMS_OFF_CTRL     12'h000
`define CMS_OFF_STATUS   12'h004
`define CMS_OFF_WREG     12'h008
`define CMS_OFF_BANK     12'h00c
`define CMS_OFF_PCHIGH   12'h010
`define CMS_OFF_PTR0     12'h014
`define CMS_OFF_PTR1     12'h018

// Field positions
`define CMS_CTRL_EN_BIT  0
`define CMS_STAT_C_BIT   0
`define CMS_STAT_Z_BIT   1
`define CMS_STAT_BSY_BIT 2

// Reset values
`define CMS_RST_CTRL     1'b0
`define CMS_RST_WREG     8'h00
`define CMS_RST_BANK     6'h00
`define CMS_RST_PCHIGH   7'h00
`define CMS_RST_PTR      16'h0000

// File addresses of the two indirect access ports
`define CMS_IND0_ADDR    7'h00
`define CMS_IND1_ADDR    7'h01

// Pointer update mode encodings
`define CMS_MODE_PREINC  2'b00
`define CMS_MODE_PREDEC  2'b01
`define CMS_MODE_POSTINC 2'b10
`define CMS_MODE_POSTDEC 2'b11

`endif

/* hw/cms_pkg.sv */
// Types for the move and shift execution block
package cms_pkg;

	// Operations handled by this block
	typedef enum logic [2:0] {
		CMS_NOP,
		logical_shift_right_op,
		copy_file_op,
		indirect_load_op,
		load_bank_select_op,
		load_page_latch_op,
		load_literal_op
	} cms_op_t;

	// Sequencer states
	typedef enum logic {
		CMS_IDLE,
		CMS_WAIT_RD
	} cms_state_t;

	// Decoded instruction from the decode stage
	typedef struct packed {
		logic       valid;
		cms_op_t    op;
		logic [6:0] f_addr;
		logic [7:0] f_data;
		logic       dest;
		logic       ptr_sel;
		logic [1:0] pointer_update_mode;
		logic       rel;
		logic [5:0] offset;
		logic [7:0] literal;
	} cms_instr_t;

	// Data memory request
	typedef struct packed {
		logic        valid;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cms_mem_req_t;

	// File register write-back
	typedef struct packed {
		logic       valid;
		logic [6:0] addr;
		logic [7:0] data;
	} cms_file_wr_t;

endpackage : cms_pkg

/* testbench/cms_mem_model.sv */
// Data memory model answering indirect reads, alternately prompt and slow
`timescale 1ns/1ps

module cms_mem_model
	import cms_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire cms_mem_req_t mem_req,
	output logic              mem_rvalid,
	output logic [7:0]        mem_rdata
);
	logic        pend;
	logic        slow;
	logic [1:0]  wait_cnt;
	logic [15:0] rd_addr;

	// Read answer after one or three cycles; data bus scrambles when idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend       <= 1'b0;
			slow       <= 1'b0;
			wait_cnt   <= 2'h0;
			rd_addr    <= 16'h0000;
			mem_rvalid <= 1'b0;
			mem_rdata  <= 8'h5a;
		end else begin
			mem_rvalid <= 1'b0;
			mem_rdata  <= ~mem_rdata; // Stale data never looks valid
			if (mem_req.valid && !mem_req.we) begin
				pend     <= 1'b1;
				rd_addr  <= mem_req.addr;
				wait_cnt <= slow ? 2'h2 : 2'h0;
				slow     <= ~slow;
			end else if (pend && wait_cnt == 2'h0) begin
				mem_rvalid <= 1'b1;
				mem_rdata  <= rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h3c;
				pend       <= 1'b0;
			end else if (pend) begin
				wait_cnt <= wait_cnt - 2'h1;
			end
		end
	end
endmodule : cms_mem_model

/* testbench/cpu_move_shift_instr_exec_tb_top.sv */
// Self-checking testbench for the move and shift execution block
`timescale 1ns/1ps
`include "cms_params.svh"

module cpu_move_shift_instr_exec_tb_top
	import cms_pkg::*;
;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata;
	cms_instr_t   instr_i;
	logic         instr_ready, mem_rvalid, done, c_flag, z_flag;
	cms_mem_req_t mem_req;
	cms_file_wr_t file_wr;
	logic [7:0]   mem_rdata, wreg, m_w;
	logic [5:0]   bank, m_b;
	logic [6:0]   pch, m_p;
	logic [15:0]  ptr [2];
	logic [15:0]  m_ptr [2];
	logic         m_c, m_z;
	logic [63:0]  exp_q [$];
	int           num_errors, check_count, i;

	cms_exec #(.PTR_W(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_i(instr_i), .instr_ready(instr_ready), .mem_req(mem_req), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata), .file_wr(file_wr), .done(done), .wreg(wreg), .c_flag(c_flag), .z_flag(z_flag),
		.bank_select_register(bank), .program_counter_high_latch(pch), .pointer_register(ptr));
	cms_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata));

	always #20 pclk = ~pclk;

	function automatic logic [7:0] mem_val(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction : mem_val

	// Expected visible state, file write data zeroed when no write
	function automatic logic [63:0] snap(input logic fw, input logic [7:0] fd);
		return {m_b, m_p, m_w, m_c, m_z, fw, fd, m_ptr[0], m_ptr[1]};
	endfunction : snap

	task automatic check(input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	// One APB transfer, entered and left just after a rising edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [32:0] r);
		int n;
		psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Pre-edge values are seen here, so the answer is taken at its edge
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		r = {pslverr, prdata};
		psel <= 1'b0; penable <= 1'b0;
		if (n == 50) begin num_errors++; end_sim(); end
		@(posedge pclk);
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [32:0] e);
		logic [32:0] r;
		apb(a, 1'b0, 32'h0, r);
		check({31'h0, e}, {31'h0, r});
	endtask : rd_chk

	// Valid stays up across back-to-back calls; caller drops it afterwards
	task automatic issue(input cms_instr_t ci, input logic [63:0] e);
		int n;
		exp_q.push_back(e);
		instr_i <= ci;
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (instr_ready === 1'b1) break;
		end
		if (n == 50) begin num_errors++; end_sim(); end
	endtask : issue

	// Shift or copy; copy from address 0 or 1 reads through a pointer
	task automatic file_op(input cms_op_t op, input logic [6:0] fa, input logic [7:0] fd, input logic d);
		cms_instr_t ci;
		logic [7:0] res;
		logic       ind;
		ci = '0; ci.valid = 1'b1; ci.op = op; ci.f_addr = fa; ci.f_data = fd; ci.dest = d;
		ind = (op == copy_file_op && fa < 7'h02);
		res = (op == logical_shift_right_op) ? {1'b0, fd[7:1]} : fd;
		if (ind) res = mem_val(m_ptr[fa[0]]);
		if (op == logical_shift_right_op) m_c = fd[0];
		m_z = (res == 8'h00);
		if (!d) m_w = res;
		// A redirected copy back goes to data memory, never to the file
		issue(ci, snap(d && !ind, (d && !ind) ? res : 8'h00));
	endtask : file_op

	task automatic ind_op(input logic ps, input logic [1:0] mode, input logic rel, input logic [5:0] off);
		cms_instr_t ci;
		logic [15:0] ea, nw;
		ci = '0; ci.valid = 1'b1; ci.op = indirect_load_op; ci.ptr_sel = ps;
		ci.pointer_update_mode = mode; ci.rel = rel; ci.offset = off;
		nw = mode[0] ? m_ptr[ps] - 16'h1 : m_ptr[ps] + 16'h1;
		ea = rel ? m_ptr[ps] + {{10{off[5]}}, off} : (mode[1] ? m_ptr[ps] : nw);
		if (!rel) m_ptr[ps] = nw;
		m_w = mem_val(ea);
		m_z = (m_w == 8'h00);
		issue(ci, snap(1'b0, 8'h00));
	endtask : ind_op

	task automatic lit_op(input cms_op_t op, input logic [7:0] k);
		cms_instr_t ci;
		ci = '0; ci.valid = 1'b1; ci.op = op; ci.literal = k;
		if (op == load_bank_select_op) m_b = k[5:0];
		if (op == load_page_latch_op) m_p = k[6:0];
		if (op == load_literal_op) m_w = k;
		issue(ci, snap(1'b0, 8'h00));
	endtask : lit_op

	task automatic drain;
		int n;
		instr_i.valid <= 1'b0;
		for (n = 0; n < 50 && exp_q.size() != 0; n++) @(posedge pclk);
		check(64'h0, {32'h0, exp_q.size()});
		@(posedge pclk);
	endtask : drain

	// Scoreboard: each done pulse retires the oldest expectation
	always @(negedge pclk) begin
		if (presetn === 1'b1 && done === 1'b1) begin
			if (exp_q.size() == 0) check(64'h0, 64'h1);
			else check(exp_q.pop_front(), {bank, pch, wreg, c_flag, z_flag, file_wr.valid,
				file_wr.valid ? file_wr.data : 8'h00, ptr[0], ptr[1]});
		end
	end

	initial begin
		#2000000;
		num_errors++;
		end_sim();
	end

	initial begin
		logic [32:0] r;
		void'($urandom(77629));
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; instr_i = '0;
		num_errors = 0; check_count = 0;
		m_w = 8'h00; m_c = 1'b0; m_z = 1'b0; m_b = 6'h00; m_p = 7'h00;
		m_ptr[0] = 16'hffff; m_ptr[1] = 16'h0000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(`CMS_OFF_CTRL, 33'h0);
		rd_chk(`CMS_OFF_WREG, 33'h0);
		rd_chk(`CMS_OFF_PTR0, 33'h0);
		rd_chk(12'h01c, 33'h100000000);
		check(64'h0, {63'h0, instr_ready});
		apb(`CMS_OFF_CTRL, 1'b1, 32'h1, r);
		apb(`CMS_OFF_PTR0, 1'b1, 32'hffff, r);
		// Shifts and copies back to back, boundaries then random, then the three literal loads
		file_op(logical_shift_right_op, 7'h10, 8'h01, 1'b0);
		file_op(logical_shift_right_op, 7'h11, 8'h00, 1'b1);
		for (i = 0; i < 8; i++)
			file_op(i[0] ? copy_file_op : logical_shift_right_op, 7'h20, 8'($urandom), i[1]);
		file_op(copy_file_op, 7'h05, 8'h00, 1'b1);
		lit_op(load_bank_select_op, 8'($urandom));
		lit_op(load_page_latch_op, 8'h7f);
		lit_op(load_literal_op, 8'($urandom));
		drain();
		// Indirect loads in every mode, with wrap and offset extremes, and copies through both indirect ports
		ind_op(1'b0, `CMS_MODE_PREINC, 1'b0, 6'h00);
		ind_op(1'b1, `CMS_MODE_PREDEC, 1'b0, 6'h00);
		ind_op(1'b0, `CMS_MODE_POSTINC, 1'b0, 6'h00);
		ind_op(1'b0, `CMS_MODE_POSTDEC, 1'b0, 6'h00);
		ind_op(1'b1, `CMS_MODE_POSTINC, 1'b1, 6'h20);
		ind_op(1'b1, `CMS_MODE_PREDEC, 1'b1, 6'h1f);
		file_op(copy_file_op, 7'h01, 8'h00, 1'b0);
		ind_op(1'b0, `CMS_MODE_POSTDEC, 1'b0, 6'h00);
		file_op(copy_file_op, 7'h00, 8'h00, 1'b1);
		drain();
		rd_chk(`CMS_OFF_STATUS, {31'h0, m_z, m_c});
		apb(`CMS_OFF_WREG, 1'b1, 32'h1a5, r);
		rd_chk(`CMS_OFF_WREG, 33'ha5);
		end_sim();
	end
endmodule : cpu_move_shift_instr_exec_tb_top
